// *** pso_map.svh ***
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers on the internal register port
// Notes: Definitions only
`ifndef PSO_MAP_SVH
`define PSO_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSO_OFS_INPUT_CONFIG 8'h05
`define PSO_OFS_OUTPUT_SYNC_CONFIG 8'h18
`define PSO_OFS_LINE_SYNC_WIDTH 8'h19
`define PSO_OFS_POWER_CONTROL 8'h1B
`define PSO_OFS_REFERENCE_MULTIPLIER 8'h2B

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PSO_BIT_LS_POL 7
`define PSO_BIT_FS_POL 6
`define PSO_BIT_OUT48 0
`define PSO_BIT_YPBPR 2

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define PSO_RST_INPUT_CONFIG 8'h00
`define PSO_RST_OUTPUT_SYNC_CONFIG 8'h00
`define PSO_RST_LINE_SYNC_WIDTH 8'h20
`define PSO_RST_POWER_CONTROL 8'h00
`define PSO_RST_REFERENCE_MULTIPLIER 8'h14
`define PSO_STANDBY_CODE 8'h0F
`define PSO_RD_UNMAPPED 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSO_FS_PIXEL 12'h007
`define PSO_PIXEL_ZERO 12'h000

`endif

// *** pso_pkg.sv ***
// Purpose: Shared types of the sync output generator
// Assumes: Nothing
// Notes: Constants live in pso_map.svh
package pso_pkg;
  typedef logic [7:0] pso_byte_t;
  // Width quantisation mode of the line sync
  typedef enum logic [1:0] {PSO_RGB24, PSO_YPBPR24, PSO_OUT48} pso_mode_e;
endpackage

// *** pso_regfile.sv ***
// Purpose: Configuration register file with registered read data
// Assumes: One write or read per cycle on the internal register port
// Notes: Unmapped offsets read as zero and ignore writes
`timescale 1ns/1ps
`include "pso_map.svh"

module pso_regfile
  import pso_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [7:0] i_addr,
  input wire pso_byte_t i_wdata,
  output pso_byte_t o_rdata,
  output pso_byte_t o_input_config,
  output pso_byte_t o_output_sync_config,
  output pso_byte_t o_line_sync_width,
  output pso_byte_t o_power_control,
  output pso_byte_t o_reference_multiplier
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic hit_ic = (i_addr == `PSO_OFS_INPUT_CONFIG);
  wire logic hit_oc = (i_addr == `PSO_OFS_OUTPUT_SYNC_CONFIG);
  wire logic hit_lw = (i_addr == `PSO_OFS_LINE_SYNC_WIDTH);
  wire logic hit_pc = (i_addr == `PSO_OFS_POWER_CONTROL);
  wire logic hit_rm = (i_addr == `PSO_OFS_REFERENCE_MULTIPLIER);
  wire pso_byte_t next_rdata = hit_ic ? o_input_config :
                               hit_oc ? o_output_sync_config :
                               hit_lw ? o_line_sync_width :
                               hit_pc ? o_power_control :
                               hit_rm ? o_reference_multiplier : `PSO_RD_UNMAPPED;

  // Every register returns to its default on reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_input_config <= `PSO_RST_INPUT_CONFIG;
      o_output_sync_config <= `PSO_RST_OUTPUT_SYNC_CONFIG;
      o_line_sync_width <= `PSO_RST_LINE_SYNC_WIDTH;
      o_power_control <= `PSO_RST_POWER_CONTROL;
      o_reference_multiplier <= `PSO_RST_REFERENCE_MULTIPLIER;
    end else if (i_we) begin
      if (hit_ic) o_input_config <= i_wdata;
      if (hit_oc) o_output_sync_config <= i_wdata;
      if (hit_lw) o_line_sync_width <= i_wdata;
      if (hit_pc) o_power_control <= i_wdata;
      if (hit_rm) o_reference_multiplier <= i_wdata;
    end
  end

  // Read data held until the next read
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `PSO_RD_UNMAPPED;
    end else if (i_re) begin
      o_rdata <= next_rdata;
    end
  end

endmodule

// *** pso_sync_gen.sv ***
// Purpose: Line sync and frame sync outputs towards the scaler
// Assumes: i_clk is the output data clock, one pixel per cycle
// Notes: Raw syncs pass with one register stage, no line alignment
`timescale 1ns/1ps
`include "pso_map.svh"

module pso_sync_gen
  import pso_pkg::*;
#(
  // Counter width; the longest line total must fit
  parameter int CNT_W = 12
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [CNT_W-1:0] i_line_total,
  input wire logic i_vsync_active,
  input wire logic i_raw_hsync,
  input wire logic i_raw_vsync,
  output logic [7:0] o_reg_rdata,
  output logic o_line_sync_output,
  output logic o_frame_sync_output,
  output logic o_raw_horizontal_sync_output,
  output logic o_raw_vertical_sync_output,
  output logic o_standby,
  output logic o_out48_mode,
  output logic o_ypbpr_mode,
  output logic [7:0] o_reference_multiplier
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  pso_byte_t input_config;
  pso_byte_t output_sync_config;
  pso_byte_t line_sync_width;
  pso_byte_t power_control;
  pso_byte_t reference_multiplier;

  // Asynchronous low reset covers power-on and the pin alike
  pso_regfile u_regs (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_we(i_reg_we),
    .i_re(i_reg_re),
    .i_addr(i_reg_addr),
    .i_wdata(i_reg_wdata),
    .o_rdata(o_reg_rdata),
    .o_input_config(input_config),
    .o_output_sync_config(output_sync_config),
    .o_line_sync_width(line_sync_width),
    .o_power_control(power_control),
    .o_reference_multiplier(reference_multiplier)
  );

  // ----------------------------------------
  // Width quantisation
  // ----------------------------------------
  // YPbPr rounds up to odd, 48-bit down to even, RGB passes the value
  function automatic pso_byte_t quant_width(input pso_byte_t w, input pso_mode_e m);
    pso_byte_t r;
    r = w;
    unique case (m)
      PSO_OUT48: r = {w[7:1], 1'b0};
      PSO_YPBPR24: r = {w[7:1], 1'b1};
      PSO_RGB24: r = w;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Polarity
  // ----------------------------------------
  // Polarity bit clear drives the pulse high. The reset level 0 is then
  // the idle level, so no false edge follows reset; setting the bit makes
  // the pulse active low
  function automatic logic drive_level(input logic active, input logic pol);
    return active ^ pol;
  endfunction

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  // 48-bit output takes precedence over the YPbPr rounding
  // Mode bits are read live; their effect is latched at the boundary
  wire logic cfg_out48 = output_sync_config[`PSO_BIT_OUT48];
  wire logic cfg_ypbpr = input_config[`PSO_BIT_YPBPR];
  wire logic cfg_ls_pol = output_sync_config[`PSO_BIT_LS_POL];
  wire logic cfg_fs_pol = output_sync_config[`PSO_BIT_FS_POL];
  wire pso_mode_e mode = cfg_out48 ? PSO_OUT48 : (cfg_ypbpr ? PSO_YPBPR24 : PSO_RGB24);
  wire pso_byte_t width_q = quant_width(line_sync_width, mode);
  // Only the exact code enters standby; any other value keeps running
  wire logic standby_cmd = (power_control == `PSO_STANDBY_CODE);
  wire logic run = !standby_cmd;

  // ----------------------------------------
  // Pixel counter and line boundary
  // ----------------------------------------
  // Limitations:
  // - i_line_total is read every cycle; changing it mid-line reshapes that
  //   one line and may clip its sync pulse
  // - a width at or above the line total holds the pulse for the whole line
  //   except pixel 0
  // - frame sync looks at i_vsync_active only at pixel 7, so a vertical
  //   pulse that starts and ends between two pixel 7 samples is missed
  // - register writes land at the next edge, but sync shape changes wait
  //   for the next line boundary
  logic [CNT_W-1:0] pix_cnt;
  pso_byte_t width_act;
  logic ls_pol;
  logic fs_pol;
  logic fs_level;

  wire logic line_end = (pix_cnt >= i_line_total - 1'b1);
  wire logic [CNT_W-1:0] next_cnt = line_end ? `PSO_PIXEL_ZERO : pix_cnt + 1'b1;
  wire logic boundary = (next_cnt == `PSO_PIXEL_ZERO);
  // Extra bit keeps the compare free of wrap-around
  wire logic [CNT_W:0] pos_plus_w = {1'b0, next_cnt} + {{(CNT_W-7){1'b0}}, width_act};
  // Active over the last W pixels, so the trailing edge falls on pixel 0
  wire logic next_ls = (pos_plus_w >= {1'b0, i_line_total}) && !boundary;
  // Vertical sync looked at once a line, at pixel 7, and held until the next
  wire logic fs_pixel = (next_cnt == `PSO_FS_PIXEL);
  wire logic next_fs = fs_pixel ? i_vsync_active : fs_level;
  // Pin levels after polarity
  wire logic next_ls_pin = drive_level(next_ls, ls_pol);
  wire logic next_fs_pin = drive_level(next_fs, fs_pol);

  // Counter stops in standby, as the pixel clock would
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pix_cnt <= `PSO_PIXEL_ZERO;
    end else if (run) begin
      pix_cnt <= next_cnt;
    end
  end

  // Settings adopted at pixel 0 so no pulse is clipped or doubled; a write
  // mid-line waits, and the pulse in flight keeps its old shape
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      width_act <= `PSO_RST_LINE_SYNC_WIDTH;
      ls_pol <= 1'b0;
      fs_pol <= 1'b0;
    end else if (run && boundary) begin
      width_act <= width_q;
      ls_pol <= cfg_ls_pol;
      fs_pol <= cfg_fs_pol;
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  // Standby stops the counter and holds both sync pins at their last level;
  // the line in which standby began is stretched, as the counter resumes
  // where it stopped
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fs_level <= 1'b0;
      o_line_sync_output <= 1'b0;
      o_frame_sync_output <= 1'b0;
    end else if (run) begin
      fs_level <= next_fs;
      o_line_sync_output <= next_ls_pin;
      o_frame_sync_output <= next_fs_pin;
    end
  end

  // ----------------------------------------
  // Raw syncs and status
  // ----------------------------------------
  // One flop keeps the pins registered; the added cycle leaves period,
  // polarity and width of the incoming syncs untouched
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_raw_horizontal_sync_output <= 1'b0;
      o_raw_vertical_sync_output <= 1'b0;
    end else begin
      o_raw_horizontal_sync_output <= i_raw_hsync;
      o_raw_vertical_sync_output <= i_raw_vsync;
    end
  end

  // Status copies keep running in standby so the host can
  // still read back the mode
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_standby <= 1'b0;
      o_out48_mode <= 1'b0;
      o_ypbpr_mode <= 1'b0;
      o_reference_multiplier <= `PSO_RST_REFERENCE_MULTIPLIER;
    end else begin
      o_standby <= standby_cmd;
      o_out48_mode <= cfg_out48;
      o_ypbpr_mode <= cfg_ypbpr;
      o_reference_multiplier <= reference_multiplier;
    end
  end

endmodule

// *** pso_sync_gen_props.sv ***
// Purpose: Port checks of the sync output generator
// Assumes: One clock, async active-low reset
// Notes: Frame sync edge check waits out register writes
`timescale 1ns/1ps
module pso_sync_gen_props (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_raw_hsync,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_line_sync_output,
  input wire logic o_frame_sync_output,
  input wire logic o_raw_horizontal_sync_output,
  input wire logic o_standby,
  input wire logic [7:0] o_reference_multiplier
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic [7:0] quiet;
  wire mapped = i_reg_addr inside {8'h05, 8'h18, 8'h19, 8'h1B, 8'h2B};
  wire wr_ref = i_reg_we && i_reg_addr == 8'h2B;
  // Cycles since last write, as a pending setting may move edges
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      quiet <= 8'h00;
    end else if (i_reg_we) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  property p_raw; i_raw_hsync |=> o_raw_horizontal_sync_output; endproperty
  property p_unmap; i_reg_re && !mapped |=> o_reg_rdata == 8'h00; endproperty
  property p_hold; !i_reg_re |=> $stable(o_reg_rdata); endproperty
  property p_stby;
    i_reg_we && i_reg_addr == 8'h1B && i_reg_wdata == 8'h0F |-> ##[1:2] o_standby;
  endproperty
  property p_ref; $changed(o_reference_multiplier) |-> $past(wr_ref) || $past(wr_ref, 2);
  endproperty
  property p_ls_frz; o_standby [*3] |-> $stable(o_line_sync_output); endproperty
  property p_fs_frz; o_standby ##1 o_standby |=> $stable(o_frame_sync_output); endproperty
  property p_fs7; $changed(o_frame_sync_output) && !o_standby && quiet > 8'h64
    |-> $past(o_line_sync_output, 7) != $past(o_line_sync_output, 8);
  endproperty
  a_raw: assert property (p_raw) else $error("raw sync lost");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_stby: assert property (p_stby) else $error("no standby");
  a_ref: assert property (p_ref) else $error("multiplier moved alone");
  a_ls_frz: assert property (p_ls_frz) else $error("line sync ran in standby");
  a_fs_frz: assert property (p_fs_frz) else $error("frame sync ran in standby");
  a_fs7: assert property (p_fs7) else $error("frame sync edge misplaced");
  c_unmap: cover property (i_reg_re && !mapped);
  c_stby: cover property ($rose(o_standby));
  c_fs: cover property ($changed(o_frame_sync_output) && quiet > 8'h64);
endmodule

// *** pso_scaler_model.sv ***
// Purpose: Scaler model timing the incoming line and frame syncs
// Assumes: Bench tells the active level of the line sync
// Notes: Widths are latched at each line sync trailing edge
`timescale 1ns/1ps
module pso_scaler_model (
  input wire logic i_clk,
  input wire logic i_ls,
  input wire logic i_fs,
  input wire logic i_ls_act,
  output logic [7:0] o_width = 8'h00,
  output logic [7:0] o_fs_gap = 8'h00
);
  logic [7:0] act_cnt = 8'h00;
  logic [7:0] gap_cnt = 8'h00;
  logic prev_ls = 1'b0;
  logic prev_fs = 1'b0;
  // Active length and distance from line start to frame sync edge
  always @(posedge i_clk) begin
    act_cnt <= (i_ls == i_ls_act) ? act_cnt + 8'h01 : 8'h00;
    if (prev_ls == i_ls_act && i_ls != i_ls_act) begin
      o_width <= act_cnt;
      gap_cnt <= 8'h01;
    end else begin
      gap_cnt <= gap_cnt + 8'h01;
    end
    if (i_fs != prev_fs) begin
      o_fs_gap <= gap_cnt;
    end
    prev_ls <= i_ls;
    prev_fs <= i_fs;
  end
endmodule

// *** pso_sync_gen_tb_top.sv ***
// Purpose: Self-checking bench of the sync output generator
// Assumes: Inputs change on the falling clock edge
// Notes: 40-pixel lines keep the reset width of 32 legal
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module pso_sync_gen_tb_top;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic vs = 1'b0;
  logic rh = 1'b0;
  logic rv = 1'b0;
  logic ls_act = 1'b0;
  logic [7:0] rdata, refm, width, gap;
  logic ls, fs, raw_h, raw_v, stby, m48, myp;
  int fails = 0;
  int num_checks = 0;
  // Offset and reset value; then input cfg, output cfg, width, expected
  logic [15:0] rtab [6] = '{16'h0500, 16'h1800, 16'h1920, 16'h1B00, 16'h2B14, 16'h3300};
  logic [31:0] wtab [6] = '{32'h00800303, 32'h04800203, 32'h00810302, 32'h04810504,
    32'h00000404, 32'h00C00101};
  pso_sync_gen #(.CNT_W(12)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_we(we),
    .i_reg_re(re), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_line_total(12'h028),
    .i_vsync_active(vs), .i_raw_hsync(rh), .i_raw_vsync(rv), .o_reg_rdata(rdata),
    .o_line_sync_output(ls), .o_frame_sync_output(fs), .o_raw_horizontal_sync_output(raw_h),
    .o_raw_vertical_sync_output(raw_v), .o_standby(stby), .o_out48_mode(m48),
    .o_ypbpr_mode(myp), .o_reference_multiplier(refm));
  pso_scaler_model u_scaler (.i_clk(i_clk), .i_ls(ls), .i_fs(fs), .i_ls_act(ls_act),
    .o_width(width), .o_fs_gap(gap));
  initial forever #5 i_clk = ~i_clk;
  // Single-cycle strobes, released on the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge i_clk);
    we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clk);
    re = 1'b1;
    addr = a;
    @(negedge i_clk);
    re = 1'b0;
    `CHK(rdata, e)
  endtask
  task automatic report_and_stop;
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence; mode waits span three lines and frame sync waits two, so new settings settle
  initial begin
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    for (int k = 0; k < 6; k++) rd(rtab[k][15:8], rtab[k][7:0]);
    for (int k = 0; k < 6; k++) begin
      wr(8'h05, wtab[k][31:24]);
      wr(8'h18, wtab[k][23:16]);
      wr(8'h19, wtab[k][15:8]);
      // Polarity bit clear drives the line sync high
      ls_act = ~wtab[k][23];
      repeat (130) @(negedge i_clk);
      `CHK(width, wtab[k][7:0])
      `CHK({m48, myp}, {wtab[k][16], wtab[k][26]})
    end
    // Frame polarity bit set makes the pulse active low
    vs = 1'b1;
    repeat (90) @(negedge i_clk);
    `CHK({fs, gap}, 9'h007)
    wr(8'h18, 8'h80);
    repeat (90) @(negedge i_clk);
    `CHK(fs, 1'b1)
    vs = 1'b0;
    repeat (90) @(negedge i_clk);
    `CHK({fs, gap}, 9'h007)
    wr(8'h1B, 8'h0F);
    rh = 1'b1;
    rv = 1'b1;
    @(negedge i_clk);
    `CHK({stby, raw_h, raw_v}, 3'b111)
    repeat (20) @(negedge i_clk);
    rd(8'h2B, 8'h14);
    wr(8'h1B, 8'h00);
    wr(8'h2B, 8'h16);
    repeat (3) @(negedge i_clk);
    `CHK(refm, 8'h16)
    wr(8'h2B, 8'h10);
    repeat (3) @(negedge i_clk);
    `CHK(refm, 8'h10)
    i_resetn = 1'b0;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    rd(8'h2B, 8'h14);
    report_and_stop();
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    report_and_stop();
  end
endmodule
bind pso_sync_gen pso_sync_gen_props u_props (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_reg_we(i_reg_we), .i_reg_re(i_reg_re), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_raw_hsync(i_raw_hsync), .o_reg_rdata(o_reg_rdata),
  .o_line_sync_output(o_line_sync_output), .o_frame_sync_output(o_frame_sync_output),
  .o_raw_horizontal_sync_output(o_raw_horizontal_sync_output), .o_standby(o_standby),
  .o_reference_multiplier(o_reference_multiplier));
